/* File: logic/host_pin_function_mux.sv */
// Purpose: device end, steers shared host pins by protocol and power state
// Assumes: protocol core and lamp engine sit on the user side
// Notes: every pin input except the strap passes two flip-flops before use; the strap is caught in one
`timescale 1ns/10ps
`default_nettype none
// How it works
// - host selects serial transfers with chip-select low
// - standby: wake pin driven high on event
// - deep sleep: wake pin input, high wakes
// - serial normal: wake pin is data input
// - bidir: one data wire, drive own phase
// - serial normal: data pin push-pull read out
// - two-wire: data pin only pulled low
// - host supplies clock; device only receives
// - lamps reset open-drain, may go push-pull
// - reset pin high returns lamp types to default
// - alert output pulled low when alerting
// - alternate link may use alert as irq
// - strap resistance picks address and protocol
// - two-wire use ties chip-select to ground
module host_pin_function_mux #(
  parameter int ALT_IRQ_ENABLE = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  host_pin_if.device pins,
  input wire pin_mux_pkg::power_t power_state, // current power state
  input wire logic wake_event, // touch seen while in standby
  input wire logic alert_req, // core asks for alert / irq
  input wire logic tx_data, // read data bit toward host
  input wire logic tx_phase, // device phase of a bidir transfer
  input wire logic lamp_cfg_wr, // strobe to load lamp types
  input wire logic [pin_mux_pkg::LAMP_COUNT-1:0] lamp_cfg, // 1 selects push-pull
  input wire logic [pin_mux_pkg::LAMP_COUNT-1:0] lamp_level, // lamp on request
  output logic [pin_mux_pkg::LAMP_COUNT-1:0] lamp_o, // lamp pin level
  output logic [pin_mux_pkg::LAMP_COUNT-1:0] lamp_oe, // lamp pin drive enable
  output pin_mux_pkg::proto_t proto, // selected protocol
  output logic [pin_mux_pkg::ADDR_W-1:0] bus_addr, // selected bus address
  output logic strap_valid, // strap has been caught
  output logic selected, // serial chip-select active
  output logic rx_data, // synchronised incoming data bit
  output logic link_clock, // synchronised serial clock level
  output logic link_clock_rise, // one-cycle pulse on clock rise
  output logic deep_wake, // wake seen in deep sleep
  output logic soft_reset // reset pin held high
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] sel_sync; // chip-select synchroniser
    logic [1:0] wake_sync; // wake pin synchroniser
    logic [1:0] data_sync; // data pin synchroniser
    logic [1:0] clk_sync; // clock pin synchroniser
    logic [1:0] rst_sync; // reset pin synchroniser
    logic clk_prev; // last clock level for edge find
    logic strapped; // strap captured once
    logic [pin_mux_pkg::STRAP_W-1:0] strap; // captured strap code
    logic [pin_mux_pkg::LAMP_COUNT-1:0] lamp_type; // per lamp output type
    logic [pin_mux_pkg::LAMP_COUNT-1:0] lamp_o;
    logic [pin_mux_pkg::LAMP_COUNT-1:0] lamp_oe;
    logic wake_o;
    logic wake_oe;
    logic data_o;
    logic data_oe;
    logic alert_oe;
    logic rx_data;
    logic deep_wake;
  } state_t;

  state_t cur;
  state_t next_cur;
  pin_mux_pkg::proto_t sel_proto; // protocol decoded from strap

  // ----------------------------------------
  // strap decode
  // ----------------------------------------
  // protocol field of the captured code
  always_comb begin
    sel_proto = pin_mux_pkg::proto_t'(cur.strap[pin_mux_pkg::STRAP_W-1:pin_mux_pkg::STRAP_PROTO_LSB]);
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_cur = cur;
    // two-flop synchronisers, first stage read only by the second
    next_cur.sel_sync = {cur.sel_sync[0], pins.chip_sel_n};
    next_cur.wake_sync = {cur.wake_sync[0], pins.wake_line};
    next_cur.data_sync = {cur.data_sync[0], pins.twowire_data};
    next_cur.clk_sync = {cur.clk_sync[0], pins.twowire_clock};
    next_cur.rst_sync = {cur.rst_sync[0], pins.reset_pin};
    next_cur.clk_prev = cur.clk_sync[1];

    // strap caught at the first edge after reset release
    if (!cur.strapped) begin
      next_cur.strapped = 1'b1;
      next_cur.strap = pins.addr_proto_select;
    end

    // lamp type register, soft reset has priority
    if (cur.rst_sync[1]) begin
      next_cur.lamp_type = {pin_mux_pkg::LAMP_COUNT{pin_mux_pkg::LAMP_OPEN_DRAIN}};
    end else if (lamp_cfg_wr) begin
      next_cur.lamp_type = lamp_cfg;
    end

    // lamp pins: open-drain only sinks, push-pull drives both levels
    for (int i = 0; i < pin_mux_pkg::LAMP_COUNT; i++) begin
      if (cur.lamp_type[i] == pin_mux_pkg::LAMP_PUSH_PULL) begin
        next_cur.lamp_o[i] = lamp_level[i];
        next_cur.lamp_oe[i] = 1'b1;
      end else begin
        next_cur.lamp_o[i] = 1'b0;
        next_cur.lamp_oe[i] = lamp_level[i];
      end
    end

    // defaults: every shared pin released
    next_cur.wake_o = 1'b0;
    next_cur.wake_oe = 1'b0;
    next_cur.data_o = 1'b0;
    next_cur.data_oe = 1'b0;
    next_cur.alert_oe = 1'b0;
    next_cur.rx_data = cur.data_sync[1];

    // all pin roles from one protocol choice
    case (sel_proto)
      pin_mux_pkg::PROTO_TWOWIRE: begin
        // sink only, pull-up gives the high
        next_cur.data_oe = ~tx_data;
        next_cur.alert_oe = alert_req;
      end
      pin_mux_pkg::PROTO_ALT_LINK: begin
        next_cur.data_oe = ~tx_data;
        next_cur.alert_oe = (ALT_IRQ_ENABLE != 0) && alert_req;
      end
      pin_mux_pkg::PROTO_SERIAL_NORMAL: begin
        // input on wake pin, push-pull output while selected
        next_cur.rx_data = cur.wake_sync[1];
        next_cur.data_o = tx_data;
        next_cur.data_oe = ~cur.sel_sync[1];
        next_cur.alert_oe = alert_req;
      end
      pin_mux_pkg::PROTO_SERIAL_BIDIR: begin
        // drive only in the device phase of a selected transfer
        next_cur.data_o = tx_data;
        next_cur.data_oe = ~cur.sel_sync[1] & tx_phase;
        next_cur.alert_oe = alert_req;
      end
      default: begin
        next_cur.data_oe = 1'b0;
      end
    endcase

    // wake pin roles outside serial normal mode
    next_cur.deep_wake = 1'b0;
    if (sel_proto != pin_mux_pkg::PROTO_SERIAL_NORMAL) begin
      if (power_state == pin_mux_pkg::PWR_STANDBY) begin
        next_cur.wake_oe = 1'b1;
        next_cur.wake_o = wake_event;
      end else if (power_state == pin_mux_pkg::PWR_DEEP_SLEEP) begin
        next_cur.deep_wake = cur.wake_sync[1];
      end
    end else if (power_state == pin_mux_pkg::PWR_DEEP_SLEEP) begin
      // serial input still wakes from deep sleep
      next_cur.deep_wake = cur.wake_sync[1];
    end

    // pins stay released until the strap is known
    if (!cur.strapped) begin
      next_cur.data_oe = 1'b0;
      next_cur.wake_oe = 1'b0;
      next_cur.alert_oe = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // all state in one flop bank, synchronisers reset to idle levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.sel_sync <= 2'h3;
      // clock and data idle high, so no false edge after release
      cur.clk_sync <= 2'h3;
      cur.clk_prev <= 1'b1;
      cur.data_sync <= 2'h3;
      cur.strap <= pin_mux_pkg::STRAP_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pins.wake_dev_o = cur.wake_o;
  assign pins.wake_dev_oe = cur.wake_oe;
  assign pins.data_dev_o = cur.data_o;
  assign pins.data_dev_oe = cur.data_oe;
  assign pins.alert_oe = cur.alert_oe;
  assign lamp_o = cur.lamp_o;
  assign lamp_oe = cur.lamp_oe;
  assign proto = sel_proto;
  assign bus_addr = pin_mux_pkg::ADDR_BASE + {{(pin_mux_pkg::ADDR_W-1){1'b0}}, cur.strap[0]};
  assign strap_valid = cur.strapped;
  assign selected = ~cur.sel_sync[1];
  assign rx_data = cur.rx_data;
  assign link_clock = cur.clk_sync[1];
  assign link_clock_rise = cur.clk_sync[1] & ~cur.clk_prev;
  assign deep_wake = cur.deep_wake;
  assign soft_reset = cur.rst_sync[1];

endmodule
`default_nettype wire

/* File: logic/pin_mux_pkg.sv */
// Purpose: shared constants and types for the host pin steering block
// Assumes: both ends compile against this package
// Notes: strap codes and divider figures are plain defaults
`default_nettype none
package pin_mux_pkg;

  // ----------------------------------------
  // protocol and power selections
  // ----------------------------------------
  typedef enum logic [1:0] {
    PROTO_TWOWIRE,
    PROTO_ALT_LINK,
    PROTO_SERIAL_NORMAL,
    PROTO_SERIAL_BIDIR
  } proto_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_STANDBY,
    PWR_DEEP_SLEEP
  } power_t;

  // ----------------------------------------
  // address strap decode
  // ----------------------------------------
  localparam int STRAP_W = 3;
  localparam int ADDR_W = 7;
  // strap code bit 2..1 picks protocol, bit 0 picks address
  localparam int STRAP_PROTO_LSB = 1;
  localparam logic [ADDR_W-1:0] ADDR_BASE = 7'h28;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 3'h0;

  // ----------------------------------------
  // link clock made by the host end
  // ----------------------------------------
  localparam int LINK_PERIOD_NS = 1000;
  localparam int SYS_PERIOD_NS = 10;
  localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / SYS_PERIOD_NS / 2;

  // ----------------------------------------
  // lamp output types
  // ----------------------------------------
  localparam logic LAMP_OPEN_DRAIN = 1'b0;
  localparam logic LAMP_PUSH_PULL = 1'b1;
  localparam int LAMP_COUNT = 2;

endpackage
`default_nettype wire

/* File: logic/host_pin_if.sv */
// Purpose: pins between the touch controller and its host
// Assumes: pull-down on wake, pull-ups on data and alert
// Notes: wire levels are resolved here from each enable
`timescale 1ns/10ps
`default_nettype none
interface host_pin_if;

  // ----------------------------------------
  // pins driven by one side only
  // ----------------------------------------
  logic chip_sel_n; // host, low selects
  logic twowire_clock; // host, serial clock for every protocol
  logic reset_pin; // host, high holds soft reset
  logic [pin_mux_pkg::STRAP_W-1:0] addr_proto_select; // board strap
  logic alert_oe; // device pulls alert low

  // ----------------------------------------
  // shared wake / serial input pin
  // ----------------------------------------
  logic wake_dev_o;
  logic wake_dev_oe;
  logic wake_host_o;
  logic wake_host_oe;

  // ----------------------------------------
  // shared data pin
  // ----------------------------------------
  logic data_dev_o;
  logic data_dev_oe;
  logic data_host_o;
  logic data_host_oe;

  // resolved levels
  logic wake_line;
  logic twowire_data;
  logic alert_n;

  // wake pin idles low through its pull-down
  assign wake_line = wake_dev_oe ? wake_dev_o : (wake_host_oe ? wake_host_o : 1'b0);
  // any low driver wins, else a push-pull high or the pull-up
  assign twowire_data = ~((data_dev_oe & ~data_dev_o) | (data_host_oe & ~data_host_o));
  assign alert_n = ~alert_oe;

  modport device (
    input chip_sel_n, twowire_clock, reset_pin, addr_proto_select,
    input wake_line, twowire_data,
    output alert_oe, wake_dev_o, wake_dev_oe, data_dev_o, data_dev_oe
  );

  modport host (
    output chip_sel_n, twowire_clock, reset_pin, addr_proto_select,
    output wake_host_o, wake_host_oe, data_host_o, data_host_oe,
    input wake_line, twowire_data, alert_n
  );

endinterface
`default_nettype wire

/* File: logic/host_pin_driver.sv */
// Purpose: host end, drives select, clock, reset and strap pins
// Assumes: host user logic tells it the protocol in use
// Notes: the link clock is divided down from clk
`timescale 1ns/10ps
`default_nettype none
module host_pin_driver #(
  parameter int HALF_CYCLES = pin_mux_pkg::LINK_HALF_CYCLES,
  parameter logic [pin_mux_pkg::STRAP_W-1:0] STRAP_CODE = pin_mux_pkg::STRAP_RESET
) (
  input wire logic clk,
  input wire logic rst_n,
  host_pin_if.host pins,
  input wire pin_mux_pkg::proto_t proto, // protocol the board is strapped for
  input wire logic select, // start a serial transfer
  input wire logic clock_run, // let the link clock toggle
  input wire logic tx_data, // data bit toward device
  input wire logic tx_phase, // host phase of a bidir transfer
  input wire logic wake_req, // drive the wake pin high
  input wire logic reset_req, // hold device in soft reset
  output logic rx_data, // synchronised device data
  output logic alert, // synchronised alert, high when asserted
  output logic wake_seen // synchronised wake pin level
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] div; // half-period counter
    logic sclk; // link clock level
    logic sel_n;
    logic rst_pin;
    logic wake_o;
    logic wake_oe;
    logic data_o;
    logic data_oe;
    logic [1:0] data_sync;
    logic [1:0] alert_sync;
    logic [1:0] wake_sync;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.data_sync = {cur.data_sync[0], pins.twowire_data};
    next_cur.alert_sync = {cur.alert_sync[0], ~pins.alert_n};
    next_cur.wake_sync = {cur.wake_sync[0], pins.wake_line};
    next_cur.rst_pin = reset_req;

    // clock divider, idles high when stopped
    // a stop waits for the high half, so no short low pulse escapes
    if (!clock_run && cur.sclk) begin
      next_cur.div = '0;
      next_cur.sclk = 1'b1;
    end else if (cur.div == 16'(HALF_CYCLES - 1)) begin
      next_cur.div = '0;
      next_cur.sclk = ~cur.sclk;
    end else begin
      next_cur.div = cur.div + 16'h0001;
    end

    next_cur.wake_o = 1'b0;
    next_cur.wake_oe = 1'b0;
    next_cur.data_o = 1'b0;
    next_cur.data_oe = 1'b0;
    next_cur.sel_n = 1'b1;
    case (proto)
      pin_mux_pkg::PROTO_SERIAL_NORMAL: begin
        next_cur.sel_n = ~select;
        next_cur.wake_o = tx_data;
        next_cur.wake_oe = select;
      end
      pin_mux_pkg::PROTO_SERIAL_BIDIR: begin
        next_cur.sel_n = ~select;
        next_cur.data_o = tx_data;
        next_cur.data_oe = select & tx_phase;
        next_cur.wake_o = 1'b1;
        next_cur.wake_oe = wake_req;
      end
      default: begin
        // two-wire modes: select tied low, data sink only
        next_cur.sel_n = 1'b0;
        next_cur.data_oe = ~tx_data;
        next_cur.wake_o = 1'b1;
        next_cur.wake_oe = wake_req;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.sclk <= 1'b1;
      cur.sel_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pins.chip_sel_n = cur.sel_n;
  assign pins.twowire_clock = cur.sclk;
  assign pins.reset_pin = cur.rst_pin;
  assign pins.addr_proto_select = STRAP_CODE;
  assign pins.wake_host_o = cur.wake_o;
  assign pins.wake_host_oe = cur.wake_oe;
  assign pins.data_host_o = cur.data_o;
  assign pins.data_host_oe = cur.data_oe;
  assign rx_data = cur.data_sync[1];
  assign alert = cur.alert_sync[1];
  assign wake_seen = cur.wake_sync[1];

endmodule
`default_nettype wire

/* File: verif/host_pin_properties.sv */
// Purpose: pin-level checks beside the two-wire pair
// Assumes: inputs come straight from the joining interface
// Notes: link half period handed on as a parameter
`timescale 1ns/10ps
`default_nettype none
module host_pin_properties #(
  parameter int HALF_CYCLES = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic twowire_clock,
  input wire logic [pin_mux_pkg::STRAP_W-1:0] addr_proto_select,
  input wire logic alert_oe,
  input wire logic alert_n,
  input wire logic wake_dev_o,
  input wire logic wake_dev_oe,
  input wire logic wake_host_oe,
  input wire logic wake_line,
  input wire logic data_dev_o,
  input wire logic data_dev_oe,
  input wire logic data_host_oe,
  input wire logic twowire_data
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic prev_clock; // link clock one edge back
  int run_len; // edges the link clock held its level
  logic two_wire; // strap picks the two-wire bus
  assign two_wire = addr_proto_select[pin_mux_pkg::STRAP_PROTO_LSB +: 2] == 2'h0;
  // measure how long the link clock stands between changes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_clock <= 1'b1;
      run_len <= 0;
    end else begin
      prev_clock <= twowire_clock;
      run_len <= (twowire_clock != prev_clock) ? 0 : run_len + 1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  pins_released_a: assert property ($past(rst_n, 2) == 1'b0 |->
    !data_dev_oe && !wake_dev_oe && !alert_oe) else $error("pins driven right after reset");
  data_open_drain_a: assert property (two_wire && data_dev_oe |-> !data_dev_o)
    else $error("two-wire data driven high");
  data_pull_low_a: assert property (data_dev_oe && !data_dev_o |-> !twowire_data)
    else $error("data line not low while pulled");
  data_pull_up_a: assert property (two_wire && !data_dev_oe && !data_host_oe
    |-> twowire_data) else $error("released data line not high");
  alert_level_a: assert property (alert_n != alert_oe)
    else $error("alert line disagrees with its enable");
  wake_pulldown_a: assert property (!wake_dev_oe && !wake_host_oe |-> !wake_line)
    else $error("idle wake line not low");
  wake_dev_wins_a: assert property (wake_dev_oe |-> wake_line == wake_dev_o)
    else $error("wake line not the device level");
  clock_half_a: assert property (twowire_clock != prev_clock
    |-> run_len >= HALF_CYCLES - 1) else $error("link clock half period too short");
  // main scenarios seen
  cover property (data_dev_oe && !twowire_data);
  cover property (wake_dev_oe && wake_line);
  cover property (alert_oe);
endmodule
`default_nettype wire

/* File: verif/host_pin_function_mux_bench.sv */
// Purpose: drives one pair per protocol end to end, four pairs in all
// Assumes: all four pairs share the user-side stimulus
// Notes: link clock divider shortened to two cycles a half
`timescale 1ns/10ps
`default_nettype none
module host_pin_function_mux_bench;
  localparam int HALF = 2; // link half period in clk cycles
  logic clk = 1'b0, rst_n = 1'b0; // system clock and reset
  pin_mux_pkg::power_t power_state = pin_mux_pkg::PWR_ACTIVE; // device power
  logic wake_event = 1'b0, alert_req = 1'b0, dev_tx = 1'b1, dev_phase = 1'b0; // device user
  logic lamp_cfg_wr = 1'b0; // lamp type strobe
  logic [1:0] lamp_cfg = 2'h0, lamp_level = 2'h0; // lamp type and level
  logic select = 1'b0, clock_run = 1'b0, host_tx = 1'b1, host_phase = 1'b0; // host user
  logic wake_req = 1'b0, reset_req = 1'b0; // host wake and soft reset
  logic [1:0] lamp_o [4], lamp_oe [4]; // lamp pins per pair
  pin_mux_pkg::proto_t proto_seen [4]; // decoded protocol
  logic [pin_mux_pkg::ADDR_W-1:0] bus_addr [4]; // decoded address
  logic [3:0] strap_valid, selected, dev_rx, link_clock, link_rise, deep_wake; // per pair
  logic [3:0] soft_reset, host_rx, alert_seen, wake_seen; // per pair
  int miscompares = 0, tests_run = 0, cycles = 0; // counters
  // board strap per pair: two-wire, serial normal, alternate link, serial bidir
  localparam logic [2:0] STRAPS [4] = '{3'h1, 3'h4, 3'h2, 3'h6};
  host_pin_if pins [4] ();
  // ----------------------------------------
  // one end-to-end pair per protocol
  // ----------------------------------------
  for (genvar g = 0; g < 4; g++) begin : pair
    host_pin_driver #(.HALF_CYCLES(HALF), .STRAP_CODE(STRAPS[g])) u_host_pin_driver (
      .clk(clk), .rst_n(rst_n), .pins(pins[g]),
      .proto(pin_mux_pkg::proto_t'(STRAPS[g][2:1])),
      .select(select), .clock_run(clock_run), .tx_data(host_tx), .tx_phase(host_phase),
      .wake_req(wake_req), .reset_req(reset_req), .rx_data(host_rx[g]),
      .alert(alert_seen[g]), .wake_seen(wake_seen[g]));
    host_pin_function_mux u_host_pin_function_mux (
      .clk(clk), .rst_n(rst_n), .pins(pins[g]), .power_state(power_state),
      .wake_event(wake_event), .alert_req(alert_req), .tx_data(dev_tx), .tx_phase(dev_phase),
      .lamp_cfg_wr(lamp_cfg_wr), .lamp_cfg(lamp_cfg), .lamp_level(lamp_level),
      .lamp_o(lamp_o[g]), .lamp_oe(lamp_oe[g]), .proto(proto_seen[g]),
      .bus_addr(bus_addr[g]), .strap_valid(strap_valid[g]), .selected(selected[g]),
      .rx_data(dev_rx[g]), .link_clock(link_clock[g]), .link_clock_rise(link_rise[g]),
      .deep_wake(deep_wake[g]), .soft_reset(soft_reset[g]));
  end
  host_pin_properties #(.HALF_CYCLES(HALF)) u_host_pin_properties (
    .clk(clk), .rst_n(rst_n), .twowire_clock(pins[0].twowire_clock),
    .addr_proto_select(pins[0].addr_proto_select), .alert_oe(pins[0].alert_oe),
    .alert_n(pins[0].alert_n), .wake_dev_o(pins[0].wake_dev_o),
    .wake_dev_oe(pins[0].wake_dev_oe), .wake_host_oe(pins[0].wake_host_oe),
    .wake_line(pins[0].wake_line), .data_dev_o(pins[0].data_dev_o),
    .data_dev_oe(pins[0].data_dev_oe), .data_host_oe(pins[0].data_host_oe),
    .twowire_data(pins[0].twowire_data));
  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic test_strap();
    int rises;
    rises = 0;
    check("proto0", pin_mux_pkg::PROTO_TWOWIRE, proto_seen[0]);
    check("proto1", pin_mux_pkg::PROTO_SERIAL_NORMAL, proto_seen[1]);
    check("addr0", pin_mux_pkg::ADDR_BASE + 7'h01, bus_addr[0]);
    check("addr1", pin_mux_pkg::ADDR_BASE, bus_addr[1]);
    check("proto2", pin_mux_pkg::PROTO_ALT_LINK, proto_seen[2]);
    check("proto3", pin_mux_pkg::PROTO_SERIAL_BIDIR, proto_seen[3]);
    check("strap", 8'h0F, strap_valid);
    check("sel_tied", 8'h05, selected);
    check("idle_oe", 8'h00, {pins[1].data_dev_oe, pins[0].data_dev_oe});
    repeat (16) begin
      @(negedge clk);
      rises += link_rise[0];
    end
    check("rises", 8'h04, rises[7:0]);
    // stopped link clock must rest high at the device
    clock_run = 1'b0;
    step(8);
    check("lclk_idle", 8'h0F, link_clock);
    clock_run = 1'b1;
    $display("test_strap done");
  endtask
  task automatic test_twowire();
    dev_tx = 1'b0;
    step(3);
    check("tw_low", 8'h00, {pins[2].twowire_data, pins[0].twowire_data});
    step(4);
    check("tw_rx", 8'h00, {dev_rx[0], host_rx[0]});
    dev_tx = 1'b1;
    step(3);
    check("tw_rel", 8'h01, {pins[0].data_dev_oe, pins[0].twowire_data});
    check("sn_idle", 8'h00, pins[1].data_dev_oe);
    $display("test_twowire done");
  endtask
  task automatic test_serial();
    select = 1'b1;
    dev_tx = 1'b0;
    step(6);
    check("sel", 8'h01, selected[1]);
    check("sn_low", 8'h04, {pins[1].data_dev_oe, pins[1].twowire_data, host_rx[1]});
    dev_tx = 1'b1;
    step(3);
    check("sn_high", 8'h03, {pins[1].data_dev_oe, pins[1].data_dev_o});
    host_tx = 1'b1;
    step(8);
    check("mosi1", 8'h01, dev_rx[1]);
    host_tx = 1'b0;
    step(8);
    check("mosi0", 8'h00, dev_rx[1]);
    // bidir pair: host phase, then device phase
    host_phase = 1'b1;
    step(6);
    check("bd_host", 8'h02, {pins[3].data_dev_oe, pins[3].data_host_oe, dev_rx[3]});
    host_phase = 1'b0;
    dev_phase = 1'b1;
    dev_tx = 1'b0;
    step(3);
    check("bd_dev", 8'h04, {pins[3].data_dev_oe, pins[3].data_host_oe, pins[3].twowire_data});
    dev_phase = 1'b0;
    dev_tx = 1'b1;
    select = 1'b0;
    step(6);
    check("desel", 8'h00, pins[1].data_dev_oe);
    $display("test_serial done");
  endtask
  task automatic test_power();
    power_state = pin_mux_pkg::PWR_STANDBY;
    wake_event = 1'b1;
    step(3);
    check("wake_out", 8'h01, pins[0].wake_line);
    check("mosi_in", 8'h00, pins[1].wake_dev_oe);
    step(4);
    check("wake_seen", 8'h0D, wake_seen);
    wake_event = 1'b0;
    step(3);
    check("wake_low", 8'h00, pins[0].wake_line);
    power_state = pin_mux_pkg::PWR_DEEP_SLEEP;
    step(3);
    check("wake_in", 8'h00, pins[0].wake_dev_oe);
    wake_req = 1'b1;
    step(8);
    check("deep1", 8'h0D, deep_wake);
    wake_req = 1'b0;
    step(8);
    check("deep0", 8'h00, deep_wake[0]);
    power_state = pin_mux_pkg::PWR_ACTIVE;
    $display("test_power done");
  endtask
  task automatic test_alert();
    alert_req = 1'b1;
    step(3);
    check("alert_on", 8'h00, {pins[1].alert_n, pins[0].alert_n});
    check("alt_irq", 8'h00, pins[2].alert_n);
    step(4);
    check("alert_host", 8'h0F, alert_seen);
    alert_req = 1'b0;
    step(3);
    check("alert_off", 8'h03, {pins[1].alert_n, pins[0].alert_n});
    $display("test_alert done");
  endtask
  task automatic test_lamps();
    lamp_level = 2'h3;
    step(3);
    check("lamp_od", 8'h0C, {lamp_oe[0], lamp_o[0]});
    lamp_cfg = 2'h1;
    lamp_cfg_wr = 1'b1;
    step(1);
    lamp_cfg_wr = 1'b0;
    step(2);
    check("lamp_pp", 8'hDD, {lamp_oe[1], lamp_o[1], lamp_oe[0], lamp_o[0]});
    reset_req = 1'b1;
    step(6);
    check("soft_on", 8'h0F, soft_reset);
    check("lamp_rst", 8'h0C, {lamp_oe[0], lamp_o[0]});
    reset_req = 1'b0;
    step(6);
    check("soft_off", 8'h00, soft_reset);
    check("lamp_def", 8'h0C, {lamp_oe[0], lamp_o[0]});
    lamp_level = 2'h0;
    $display("test_lamps done");
  endtask
  // main sequence
  initial begin
    step(20);
    rst_n = 1'b1;
    clock_run = 1'b1;
    step(4);
    test_strap();
    test_twowire();
    test_serial();
    test_power();
    test_alert();
    test_lamps();
    end_of_test();
  end
endmodule
`default_nettype wire
